// File: hw/uab_device.sv
// Operation
// [RULE1] Auto-baud only in async mode; with wake set it waits for a break first
// [RULE2] Start bit with enable set starts measurement
// [RULE3] Enable clears counter, then awaits start bit
// [RULE4] Remote sends 55h for measurement
// [RULE5] Count from first rising edge, eight bits
// [RULE6] Fifth rising edge clears enable, keeps value
// [RULE7] Counter wrap sets overflow; software may write
// [RULE8] Wrap does not end measurement
// [RULE9] Measurement clock is one eighth rate
// [RULE10] Counter clock 512, 128 or 32 divide
// [RULE11] Both divisor bytes count as 16 bits
// [RULE12] Software checks high byte zero for 8-bit
// [RULE13] Receiver held idle during measurement
// [RULE14] Fifth edge sets done; software reads, discards
// [RULE15] Wake plus enable measures byte after break
// [RULE16] No transmit during measurement
// [RULE17] Sync select clear gives async mode
// [RULE18] Frame: start, 8 or 9 bits, stop
// [RULE19] LSB first, shared format and rate
// [RULE20] Generator runs x4, x16 or x64 bit rate
// [RULE21] Divider is 8 or 16 bits; the code always uses all 16 bits of div_q, whatever the selects
// [RULE22] No hardware parity; ninth bit carries it
// [RULE23] Both selects set: rate Fosc/(4(n+1))
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uab_consts.svh"
module uab_device (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // AXI4-Lite write
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [`UAB_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [`UAB_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Serial link
  uab_if.device link
);
  import uab_pkg::*;

  logic [`UAB_CTRL_W-1:0] ctrl_q;
  logic [15:0] div_q;
  logic ovf_q, done_q, ferr_q, rx9_q, txfull_q;
  logic [7:0] rxd_q;
  logic [8:0] txb_q;
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [`UAB_ADDR_W-1:0] awa_q;
  logic [31:0] wd_q, rdata_q, rd_word;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_go;
  logic [31:0] wm;
  logic line_q, ln, rise, fall;
  uab_ab_state_t ab_q;
  logic [2:0] ed_q;
  logic [11:0] cc_q;
  logic ab_act, ab_go, cc_tick, ab_end, hs, wide, nine, run;
  logic [15:0] brg_q;
  logic gen_tick;
  logic [6:0] tpb, rsub_q, tsub_q;
  logic [3:0] last, rbit_q, tbit_q;
  uab_ser_state_t rs_q, ts_q;
  logic [8:0] rsh_q, tsh_q;
  logic rx_run, tx_run, rx_fin, tx_load, tx_line_q;

  // Bus slave: one write and one read in flight
  assign s_axi_awready_out = !aw_q && !bvalid_q;
  assign s_axi_wready_out = !w_q && !bvalid_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  assign rd_go = s_axi_arvalid_in && !rvalid_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `UAB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata_in;
        ws_q <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= uab_mapped(awa_q) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr_in)
      `UAB_OFS_CTRL: rd_word[`UAB_CTRL_W-1:0] = ctrl_q;
      `UAB_OFS_STAT: begin
        rd_word[`UAB_S_DONE] = done_q;
        rd_word[`UAB_S_TXBUSY] = (ts_q != SR_IDLE) || txfull_q;
        rd_word[`UAB_S_FERR] = ferr_q;
        rd_word[`UAB_S_OVF] = ovf_q;
        rd_word[`UAB_S_RX9] = rx9_q;
        rd_word[`UAB_S_TXFULL] = txfull_q;
      end
      `UAB_OFS_DIV: rd_word[15:0] = div_q;
      `UAB_OFS_TXB: rd_word[8:0] = txb_q;
      `UAB_OFS_RXD: rd_word[7:0] = rxd_q;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `UAB_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= uab_mapped(s_axi_araddr_in) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control register; hardware clears the enable at the fifth edge
  always_comb wm = uab_merge({{(32-`UAB_CTRL_W){1'b0}}, ctrl_q}, wd_q, ws_q);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `UAB_CTRL_RST;
    end else if (wr_go && awa_q == `UAB_OFS_CTRL) begin
      ctrl_q <= wm[`UAB_CTRL_W-1:0];
    end else if (ab_end) begin
      ctrl_q[`UAB_C_ABD] <= 1'b0; // RULE6
    end
  end

  assign hs = ctrl_q[`UAB_C_HS];
  assign wide = ctrl_q[`UAB_C_WIDE];
  assign nine = ctrl_q[`UAB_C_NINE];
  assign run = !ctrl_q[`UAB_C_SYNC]; // RULE17
  assign ab_act = ab_q != AB_IDLE;
  assign ab_go = ctrl_q[`UAB_C_ABD] && run; // RULE1
  assign tpb = uab_tpb(hs, wide); // RULE20
  assign last = nine ? `UAB_LAST9 : `UAB_LAST8; // RULE18

  // Line edges; the pin is already synchronous
  assign ln = link.serial_in_line;
  assign rise = !line_q && ln;
  assign fall = line_q && !ln;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) line_q <= 1'b1;
    else line_q <= ln;
  end

  // Auto-baud measurement
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ab_q <= AB_IDLE;
    end else if (ab_act && !ab_go) begin
      ab_q <= AB_IDLE;
    end else begin
      case (ab_q)
        AB_IDLE: if (ab_go) ab_q <= ctrl_q[`UAB_C_WAKE] ? AB_BREAK : AB_START; // RULE3 RULE15
        AB_BREAK: if (rise) ab_q <= AB_START; // RULE15
        AB_START: if (fall) ab_q <= AB_FIRST; // RULE2
        AB_FIRST: if (rise) ab_q <= AB_COUNT; // RULE5
        AB_COUNT: if (ab_end) ab_q <= AB_IDLE; // RULE8
        default: ab_q <= AB_IDLE;
      endcase
    end
  end

  assign ab_end = ab_q == AB_COUNT && rise && ed_q == `UAB_ABD_EDGES - 3'h1; // RULE6
  assign cc_tick = ab_q == AB_COUNT && cc_q == uab_cc_limit(hs, wide); // RULE9 RULE10

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ed_q <= '0;
      cc_q <= '0;
    end else if (ab_q == AB_FIRST) begin
      ed_q <= 3'h1;
      cc_q <= '0;
    end else if (ab_q == AB_COUNT) begin
      if (rise) ed_q <= ed_q + 3'h1;
      cc_q <= cc_tick ? 12'h000 : cc_q + 12'h001;
    end
  end

  // Divisor pair, a full 16-bit counter while measuring
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= '0;
    end else if (ab_q == AB_IDLE && ab_go) begin
      div_q <= '0; // RULE3
    end else if (cc_tick) begin
      div_q <= div_q + 16'h0001; // RULE11 RULE5
    end else if (!ab_act && wr_go && awa_q == `UAB_OFS_DIV) begin
      div_q <= wm[15:0]; // RULE21
    end
  end

  // Overflow: hardware set wins over a software clear
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) ovf_q <= 1'b0;
    else if (cc_tick && div_q == `UAB_DIV_MAX) ovf_q <= 1'b1; // RULE7
    else if (wr_go && awa_q == `UAB_OFS_STAT && ws_q[0]) ovf_q <= wd_q[`UAB_S_OVF]; // RULE7
  end

  // Done flag cleared by reading received data; set wins
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) done_q <= 1'b0;
    else if (ab_end || rx_fin) done_q <= 1'b1; // RULE14
    else if (rd_go && s_axi_araddr_in == `UAB_OFS_RXD) done_q <= 1'b0; // RULE14
  end

  // Bit-rate generator: ticks every n+1 clocks, tpb ticks per bit
  assign gen_tick = !ab_act && brg_q == 16'h0000;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) brg_q <= '0;
    else if (ab_act || gen_tick) brg_q <= div_q; // RULE21 RULE23
    else brg_q <= brg_q - 16'h0001;
  end

  // Receiver, mid-bit sampling, LSB first
  assign rx_run = ctrl_q[`UAB_C_RXEN] && run && !ab_act; // RULE13
  assign rx_fin = rx_run && rs_q == SR_STOP && gen_tick && rsub_q == tpb - 7'h01;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rs_q <= SR_IDLE;
      rsub_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      rxd_q <= '0;
      rx9_q <= 1'b0;
      ferr_q <= 1'b0;
    end else if (!rx_run) begin
      rs_q <= SR_IDLE;
    end else begin
      case (rs_q)
        SR_IDLE: if (fall) begin
          rs_q <= SR_START;
          rsub_q <= '0;
        end
        SR_START: if (gen_tick) begin
          if (rsub_q == (tpb >> 1) - 7'h01) begin
            rsub_q <= '0;
            rbit_q <= '0;
            rs_q <= ln ? SR_IDLE : SR_DATA;
          end else rsub_q <= rsub_q + 7'h01;
        end
        SR_DATA: if (gen_tick) begin
          if (rsub_q == tpb - 7'h01) begin
            rsub_q <= '0;
            rsh_q <= {ln, rsh_q[8:1]}; // RULE19
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == last) rs_q <= SR_STOP;
          end else rsub_q <= rsub_q + 7'h01;
        end
        SR_STOP: if (gen_tick) begin
          if (rsub_q == tpb - 7'h01) begin
            rs_q <= SR_IDLE;
            rxd_q <= nine ? rsh_q[7:0] : rsh_q[8:1];
            rx9_q <= nine && rsh_q[8]; // RULE22
            ferr_q <= !ln;
          end else rsub_q <= rsub_q + 7'h01;
        end
        default: rs_q <= SR_IDLE;
      endcase
    end
  end

  // Transmit buffer; writes are dropped while auto-baud is enabled
  assign tx_run = ctrl_q[`UAB_C_TXEN] && run && !ab_act; // RULE16
  // Load on a generator tick, else the start bit comes out short
  assign tx_load = tx_run && ts_q == SR_IDLE && txfull_q && gen_tick;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      txb_q <= '0;
      txfull_q <= 1'b0;
    end else if (wr_go && awa_q == `UAB_OFS_TXB && !ctrl_q[`UAB_C_ABD]) begin
      txb_q <= wd_q[8:0]; // RULE16
      txfull_q <= 1'b1;
    end else if (tx_load) begin
      txfull_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ts_q <= SR_IDLE;
      tsub_q <= '0;
      tbit_q <= '0;
      tsh_q <= '0;
      tx_line_q <= 1'b1;
    end else if (!tx_run) begin
      ts_q <= SR_IDLE;
      tx_line_q <= 1'b1;
    end else begin
      case (ts_q)
        SR_IDLE: if (tx_load) begin
          ts_q <= SR_START;
          tsh_q <= txb_q;
          tsub_q <= '0;
          tx_line_q <= 1'b0; // RULE18
        end
        SR_START: if (gen_tick) begin
          if (tsub_q == tpb - 7'h01) begin
            tsub_q <= '0;
            tbit_q <= '0;
            tx_line_q <= tsh_q[0]; // RULE19
            ts_q <= SR_DATA;
          end else tsub_q <= tsub_q + 7'h01;
        end
        SR_DATA: if (gen_tick) begin
          if (tsub_q == tpb - 7'h01) begin
            tsub_q <= '0;
            tsh_q <= tsh_q >> 1;
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == last) begin
              ts_q <= SR_STOP;
              tx_line_q <= 1'b1;
            end else tx_line_q <= tsh_q[1];
          end else tsub_q <= tsub_q + 7'h01;
        end
        SR_STOP: if (gen_tick) begin
          if (tsub_q == tpb - 7'h01) ts_q <= SR_IDLE;
          else tsub_q <= tsub_q + 7'h01;
        end
        default: ts_q <= SR_IDLE;
      endcase
    end
  end

  assign link.serial_out_line = tx_line_q;
endmodule : uab_device
`default_nettype wire

// File: hw/uab_consts.svh
`ifndef UAB_CONSTS_SVH
`define UAB_CONSTS_SVH
`define UAB_ADDR_W 5
`define UAB_OFS_CTRL 5'h00
`define UAB_OFS_STAT 5'h04
`define UAB_OFS_DIV 5'h08
`define UAB_OFS_TXB 5'h0C
`define UAB_OFS_RXD 5'h10
`define UAB_CTRL_W 10
`define UAB_CTRL_RST 10'h000
`define UAB_C_ABD 0
`define UAB_C_WAKE 1
`define UAB_C_WIDE 3
`define UAB_C_SYNC 4
`define UAB_C_HS 5
`define UAB_C_NINE 6
`define UAB_C_TXEN 8
`define UAB_C_RXEN 9
`define UAB_S_DONE 0
`define UAB_S_TXBUSY 1
`define UAB_S_FERR 2
`define UAB_S_OVF 3
`define UAB_S_RX9 4
`define UAB_S_TXFULL 5
`define UAB_SYNC_BYTE 9'h055
`define UAB_ABD_EDGES 3'h5
`define UAB_DIV_MAX 16'hFFFF
`define UAB_CC_SLOW 12'hFFF
`define UAB_CC_MID 12'h3FF
`define UAB_CC_FAST 12'h0FF
`define UAB_TPB_SLOW 7'h40
`define UAB_TPB_MID 7'h10
`define UAB_TPB_FAST 7'h04
`define UAB_LAST8 4'h7
`define UAB_LAST9 4'h8
`define UAB_RESP_OKAY 2'h0
`define UAB_RESP_SLVERR 2'h2
`endif

// File: hw/uab_pkg.sv
`include "uab_consts.svh"
`default_nettype none
package uab_pkg;
  typedef enum logic [2:0] {AB_IDLE, AB_BREAK, AB_START, AB_FIRST, AB_COUNT} uab_ab_state_t;
  typedef enum logic [1:0] {SR_IDLE, SR_START, SR_DATA, SR_STOP} uab_ser_state_t;

  function automatic logic uab_mapped(input logic [`UAB_ADDR_W-1:0] a);
    return (a == `UAB_OFS_CTRL) || (a == `UAB_OFS_STAT) || (a == `UAB_OFS_DIV) ||
           (a == `UAB_OFS_TXB) || (a == `UAB_OFS_RXD);
  endfunction : uab_mapped

  function automatic logic [31:0] uab_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : uab_merge

  // Generator ticks per bit
  function automatic logic [6:0] uab_tpb(input logic hs, input logic wide);
    if (hs && wide) return `UAB_TPB_FAST;
    else if (hs || wide) return `UAB_TPB_MID;
    else return `UAB_TPB_SLOW;
  endfunction : uab_tpb

  // Measurement counter clock: counter clock divided by eight
  function automatic logic [11:0] uab_cc_limit(input logic hs, input logic wide);
    if (hs && wide) return `UAB_CC_FAST;
    else if (hs || wide) return `UAB_CC_MID;
    else return `UAB_CC_SLOW;
  endfunction : uab_cc_limit
endpackage : uab_pkg
`default_nettype wire

// File: hw/uab_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uab_if;
  logic serial_in_line;
  logic serial_out_line;
  modport device (input serial_in_line, output serial_out_line);
  modport remote (output serial_in_line, input serial_out_line);
endinterface : uab_if
`default_nettype wire

// File: hw/uab_remote.sv
`timescale 1ns/1ps
`default_nettype none
`include "uab_consts.svh"
module uab_remote #(
  parameter logic [15:0] CLKS_PER_BIT = 16'h015B
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Send side
  input wire logic send_valid_in,
  input wire logic [8:0] send_data_in,
  input wire logic sync_req_in,
  input wire logic nine_bit_in,
  output logic send_ready_out,
  // Receive side
  output logic recv_valid_out,
  output logic [8:0] recv_data_out,
  output logic recv_ferr_out,
  // Serial link
  uab_if.remote link
);
  import uab_pkg::*;

  uab_ser_state_t ts_q, rs_q;
  logic [15:0] tc_q, rc_q;
  logic [3:0] tb_q, rb_q, last;
  logic [8:0] tsh_q, rsh_q;
  logic line_q, ln_q;
  logic tend, rend;

  assign last = nine_bit_in ? `UAB_LAST9 : `UAB_LAST8;
  assign send_ready_out = ts_q == SR_IDLE;
  assign tend = tc_q == CLKS_PER_BIT - 16'h0001;
  assign rend = rc_q == CLKS_PER_BIT - 16'h0001;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ts_q <= SR_IDLE;
      tc_q <= '0;
      tb_q <= '0;
      tsh_q <= '0;
      line_q <= 1'b1;
    end else begin
      tc_q <= (ts_q == SR_IDLE || tend) ? 16'h0000 : tc_q + 16'h0001;
      case (ts_q)
        SR_IDLE: if (sync_req_in || send_valid_in) begin
          // Measurement needs alternating bits
          tsh_q <= sync_req_in ? `UAB_SYNC_BYTE : send_data_in; // RULE4
          line_q <= 1'b0;
          ts_q <= SR_START;
        end
        SR_START: if (tend) begin
          line_q <= tsh_q[0];
          tb_q <= '0;
          ts_q <= SR_DATA;
        end
        SR_DATA: if (tend) begin
          tsh_q <= tsh_q >> 1;
          tb_q <= tb_q + 4'h1;
          if (tb_q == last) begin
            line_q <= 1'b1;
            ts_q <= SR_STOP;
          end else line_q <= tsh_q[1];
        end
        SR_STOP: if (tend) ts_q <= SR_IDLE;
        default: ts_q <= SR_IDLE;
      endcase
    end
  end

  assign link.serial_in_line = line_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rs_q <= SR_IDLE;
      rc_q <= '0;
      rb_q <= '0;
      rsh_q <= '0;
      ln_q <= 1'b1;
      recv_valid_out <= 1'b0;
      recv_data_out <= '0;
      recv_ferr_out <= 1'b0;
    end else begin
      ln_q <= link.serial_out_line;
      recv_valid_out <= 1'b0;
      rc_q <= (rs_q == SR_IDLE || rend) ? 16'h0000 : rc_q + 16'h0001;
      case (rs_q)
        SR_IDLE: if (ln_q && !link.serial_out_line) rs_q <= SR_START;
        SR_START: if (rc_q == (CLKS_PER_BIT >> 1)) begin
          rc_q <= '0;
          rb_q <= '0;
          rs_q <= link.serial_out_line ? SR_IDLE : SR_DATA;
        end
        SR_DATA: if (rend) begin
          rsh_q <= {link.serial_out_line, rsh_q[8:1]};
          rb_q <= rb_q + 4'h1;
          if (rb_q == last) rs_q <= SR_STOP;
        end
        SR_STOP: if (rend) begin
          rs_q <= SR_IDLE;
          recv_valid_out <= 1'b1;
          recv_data_out <= nine_bit_in ? rsh_q : {1'b0, rsh_q[8:1]};
          recv_ferr_out <= !link.serial_out_line;
        end
        default: rs_q <= SR_IDLE;
      endcase
    end
  end
endmodule : uab_remote
`default_nettype wire

// File: dv/uab_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uab_checker #(
  parameter int B = 256
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Watched lines
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic nine_bit_in
);
  int tx_pos_q;
  int rx_pos_q;
  int last_w;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Frame length in clocks; the mode only changes between frames
  assign last_w = nine_bit_in ? 11 * B : 10 * B;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) tx_pos_q <= 0;
    else if (tx_pos_q == 0) tx_pos_q <= serial_out_line ? 0 : 1;
    else tx_pos_q <= (tx_pos_q == last_w - 1) ? 0 : tx_pos_q + 1;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) rx_pos_q <= 0;
    else if (rx_pos_q == 0) rx_pos_q <= serial_in_line ? 0 : 1;
    else rx_pos_q <= (rx_pos_q == last_w - 1) ? 0 : rx_pos_q + 1;
  end

  property p_idle_reset;
    $fell(rst_in) |-> serial_out_line && serial_in_line;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("line not idle after reset");

  property p_tx_start_hold;
    tx_pos_q == 0 && !serial_out_line |=> !serial_out_line [*8];
  endproperty
  a_tx_start_hold: assert property (p_tx_start_hold) else $error("tx start bit short");

  property p_tx_rise_aligned;
    $rose(serial_out_line) && tx_pos_q != 0 |-> tx_pos_q % B == 0;
  endproperty
  a_tx_rise_aligned: assert property (p_tx_rise_aligned) else $error("tx rise off grid");

  property p_tx_fall_aligned;
    $fell(serial_out_line) && tx_pos_q != 0 |-> tx_pos_q % B == 0;
  endproperty
  a_tx_fall_aligned: assert property (p_tx_fall_aligned) else $error("tx fall off grid");

  property p_tx_stop;
    tx_pos_q == last_w - B / 2 |-> serial_out_line;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx stop bit low");

  property p_rx_start_hold;
    rx_pos_q == 0 && !serial_in_line |=> !serial_in_line [*8];
  endproperty
  a_rx_start_hold: assert property (p_rx_start_hold) else $error("rx start bit short");

  property p_rx_rise_aligned;
    $rose(serial_in_line) && rx_pos_q != 0 |-> rx_pos_q % B == 0;
  endproperty
  a_rx_rise_aligned: assert property (p_rx_rise_aligned) else $error("rx rise off grid");

  property p_rx_fall_aligned;
    $fell(serial_in_line) && rx_pos_q != 0 |-> rx_pos_q % B == 0;
  endproperty
  a_rx_fall_aligned: assert property (p_rx_fall_aligned) else $error("rx fall off grid");

  property p_rx_stop;
    rx_pos_q == last_w - B / 2 |-> serial_in_line;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx stop bit low");

  c_tx_frame: cover property (tx_pos_q == last_w - 1);
  c_rx_frame: cover property (rx_pos_q == last_w - 1);
  c_nine: cover property (nine_bit_in && rx_pos_q == last_w - 1);
endmodule : uab_checker
`default_nettype wire

// File: dv/uart_autobaud_async_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uab_consts.svh"
module uart_autobaud_async_core_bench;
  import uab_pkg::*;
  logic clock_in, rst_in, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv;
  logic [4:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [1:0] bresp, rresp, rsp;
  logic sv, ss, nine_r, srdy, cv, cferr, got_ferr;
  logic [8:0] sd, cd, got_d;
  int miscompares = 0;
  int n_checks = 0;
  int got_n = 0;
  int k;
  logic [31:0] ab_ctrl [3] = '{32'h329, 32'h321, 32'h301};
  logic [31:0] ab_lo [3] = '{32'h7, 32'h1, 32'h0};
  logic [31:0] ab_hi [3] = '{32'h9, 32'h3, 32'h1};

  uab_if u_uab_if();
  uab_device u_uab_device(.clock_in(clock_in), .rst_in(rst_in), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_r), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .link(u_uab_if.device));
  // Remote runs 256 clocks a bit: device divisor 63 with both selects set
  uab_remote #(.CLKS_PER_BIT(16'h0100)) u_uab_remote(.clock_in(clock_in), .rst_in(rst_in),
    .send_valid_in(sv), .send_data_in(sd), .sync_req_in(ss), .nine_bit_in(nine_r),
    .send_ready_out(srdy), .recv_valid_out(cv), .recv_data_out(cd),
    .recv_ferr_out(cferr), .link(u_uab_if.remote));
  uab_checker #(.B(256)) u_uab_checker(.clock_in(clock_in), .rst_in(rst_in),
    .serial_in_line(u_uab_if.serial_in_line), .serial_out_line(u_uab_if.serial_out_line),
    .nine_bit_in(nine_r));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    if (cv === 1'b1) begin
      got_d <= cd;
      got_ferr <= cferr;
      got_n <= got_n + 1;
    end
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, lo);
    end
  endtask : chk_rng

  task automatic tick(inout int n);
    n++;
    if (n > 20000) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, n, 0);
      test_done;
    end
  endtask : tick

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_in);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clock_in);
      tick(n);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (!(bv && brdy));
    brdy <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd_bus(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge clock_in);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clock_in);
      tick(n);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rrdy));
    rrdy <= 1'b0;
    rd = rdat;
    rsp = rresp;
  endtask : rd_bus

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_bus(a);
    chk(rd & m, e);
  endtask : rd_chk

  task automatic rem_send(input logic [8:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clock_in);
    sd <= d;
    sv <= !s;
    ss <= s;
    do begin
      @(posedge clock_in);
      tick(n);
    end while (!srdy);
    sv <= 1'b0;
    ss <= 1'b0;
  endtask : rem_send

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd_bus(`UAB_OFS_STAT);
      tick(n);
    end while (rd[`UAB_S_DONE] !== 1'b1);
  endtask : wait_done

  task automatic tx_rx(input logic [31:0] d);
    int n;
    n = 0;
    k = got_n;
    wr(`UAB_OFS_TXB, d, 2'h0);
    while (got_n == k) begin
      @(posedge clock_in);
      tick(n);
    end
    chk({23'h0, got_d}, d);
    chk({31'h0, got_ferr}, 32'h0);
  endtask : tx_rx

  initial begin
    rst_in = 1'b1;
    {awv, wv, brdy, arv, rrdy, sv, ss, nine_r} = 8'h00;
    awa = 5'h00;
    ara = 5'h00;
    wd = 32'h0;
    sd = 9'h000;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_chk(`UAB_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(`UAB_OFS_STAT, 32'hFFFFFFFF, 32'h0);
    rd_chk(5'h14, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    wr(5'h14, 32'h1, 2'h2);
    wr(`UAB_OFS_CTRL, 32'h328, 2'h0);
    wr(`UAB_OFS_DIV, 32'h3F, 2'h0);
    rd_chk(`UAB_OFS_DIV, 32'hFFFFFFFF, 32'h3F);
    tx_rx(32'hA5);
    rem_send(9'h03C, 1'b0);
    wait_done;
    rd_chk(`UAB_OFS_RXD, 32'hFF, 32'h3C);
    rd_chk(`UAB_OFS_STAT, 32'h1, 32'h0);
    wr(`UAB_OFS_CTRL, 32'h368, 2'h0);
    nine_r <= 1'b1;
    tx_rx(32'h1A5);
    rem_send(9'h15A, 1'b0);
    wait_done;
    rd_chk(`UAB_OFS_STAT, 32'h10, 32'h10);
    rd_chk(`UAB_OFS_RXD, 32'hFF, 32'h5A);
    // The stop bit still runs; the checker's frame length must not drop mid-frame
    repeat (300) @(posedge clock_in);
    nine_r <= 1'b0;
    wr(`UAB_OFS_STAT, 32'h8, 2'h0);
    rd_chk(`UAB_OFS_STAT, 32'h8, 32'h8);
    wr(`UAB_OFS_STAT, 32'h0, 2'h0);
    rd_chk(`UAB_OFS_STAT, 32'h8, 32'h0);
    // One measurement per counter clock rate
    for (int i = 0; i < 3; i++) begin
      wr(`UAB_OFS_CTRL, ab_ctrl[i], 2'h0);
      rd_chk(`UAB_OFS_DIV, 32'hFFFFFFFF, 32'h0);
      wr(`UAB_OFS_TXB, 32'h77, 2'h0);
      rd_chk(`UAB_OFS_STAT, 32'h22, 32'h0);
      rem_send(9'h000, 1'b1);
      wait_done;
      rd_chk(`UAB_OFS_CTRL, 32'h1, 32'h0);
      rd_bus(`UAB_OFS_DIV);
      chk_rng(rd, ab_lo[i], ab_hi[i]);
      chk(rd & 32'hFF00, 32'h0);
      rd_bus(`UAB_OFS_RXD);
      rd_chk(`UAB_OFS_STAT, 32'h1, 32'h0);
    end
    // Measurement must skip the break and time the sync byte
    wr(`UAB_OFS_CTRL, 32'h32B, 2'h0);
    rem_send(9'h000, 1'b0);
    rem_send(9'h000, 1'b1);
    wait_done;
    rd_bus(`UAB_OFS_DIV);
    chk_rng(rd, 32'h7, 32'h9);
    rd_bus(`UAB_OFS_RXD);
    // Synchronous select keeps the measurement from starting
    wr(`UAB_OFS_CTRL, 32'h339, 2'h0);
    rem_send(9'h000, 1'b1);
    repeat (3000) @(posedge clock_in);
    rd_chk(`UAB_OFS_STAT, 32'h1, 32'h0);
    rd_chk(`UAB_OFS_CTRL, 32'h1, 32'h1);
    test_done;
  end
endmodule : uart_autobaud_async_core_bench
`default_nettype wire
